// ===== asr_receiver.sv
/*
 asr_receiver: receive half of an asynchronous serial port with 16x
 oversampled start search, majority vote, noise and framing flags,
 receive buffer, standby with address-mark or idle-line wakeup, and an
 Avalon-MM slave with waitrequest for its registers.
 assumes: BAUD_TICK is a one-cycle pulse at 16x baud from an outside
 baud generator; RXD is raw from the pin; one clock MCLK.
*/
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
// Operation
// - completed character data goes to receive buffer
// - buffer load sets full flag, irq if enabled
// - sample line at sixteen times baud rate
// - start: low after three highs, count ticks
// - start vote at 3,5,7; one high is noise
// - data bit majority of 8,9,10; disagreement noise
// - stop vote; low majority framing, disagreement noise
// - verified start kept; late highs set noise
// - framing error set together with full flag
// - resync tick count on falling edges mid-character
// - standby suppresses receiver interrupts
// - wake select: address mark or idle line
// - address mark ends standby, sets full flag
// - idle wake sets neither idle nor full
// - nine-bit mode puts ninth bit in status
// - idle count from start or stop bit
`timescale 1ns/1ps
module asr_receiver
	import asr_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        BAUD_TICK,
	input  wire logic        RXD,
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             IRQ
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		return a == o;
	endfunction

	function automatic logic [1:0] ones3(input logic [2:0] v);
		return {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	endfunction

	logic             ack;
	logic [2:0]       ctl1;
	logic             receiver_wakeup_ctl;
	logic [3:0]       mask;
	logic [3:0]       flags;
	logic [7:0]       data_buf;
	logic             r8;
	logic             rx_s1;
	logic             rx;
	asr_state_e       state;
	logic [4:0]       rt;
	logic [3:0]       idx;
	logic [1:0]       smp;
	logic [2:0]       hist;
	logic [8:0]       sh;
	logic             noise_acc;
	logic [3:0]       run;
	logic [3:0]       idle_sub;
	logic [3:0]       idle_cnt;
	logic             idle_armed;
	logic [31:0]      rd_mux;
	logic [7:0]       next_buf;
	logic [3:0]       next_flags;

	////////////////////////////////////////////////////////////////////////
	// bus slave: one wait state, then the answer
	wire req    = AVS_READ | AVS_WRITE;
	wire wr_go  = AVS_WRITE & ack;
	wire wr_st  = wr_go & hit(AVS_ADDRESS, OFS_STAT);
	wire wr_c1  = wr_go & hit(AVS_ADDRESS, OFS_CTL1);
	wire wr_c2  = wr_go & hit(AVS_ADDRESS, OFS_CTL2);
	wire wr_msk = wr_go & hit(AVS_ADDRESS, OFS_MASK);
	assign AVS_WAITREQUEST = req & ~ack;

	assign rd_mux = hit(AVS_ADDRESS, OFS_DATA) ? {24'h0, data_buf}
		: hit(AVS_ADDRESS, OFS_STAT) ? {26'h0, state == S_RECV, r8, flags}
		: hit(AVS_ADDRESS, OFS_CTL1) ? {29'h0, ctl1}
		: hit(AVS_ADDRESS, OFS_CTL2) ? {31'h0, receiver_wakeup_ctl}
		: hit(AVS_ADDRESS, OFS_MASK) ? {28'h0, mask}
		: 32'h0;

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ack <= 1'b0;
			AVS_READDATA <= 32'h0;
		end
		else
		begin
			ack <= req & ~ack;
			if (AVS_READ & ~ack)
				AVS_READDATA <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser; only rx is looked at
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_s1 <= 1'b1;
			rx <= 1'b1;
		end
		else
		begin
			rx_s1 <= RXD;
			rx <= rx_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode of the current sample
	wire       recv     = (state == S_RECV) & BAUD_TICK;
	wire [3:0] nb       = ctl1[C1_NINE] ? IDX_B9 : IDX_B8;
	wire [3:0] stop_idx = nb + 4'h1;
	wire       in_start = idx == 4'h0;
	wire       in_stop  = idx == stop_idx;
	wire       in_data  = ~in_start & ~in_stop;
	wire [2:0] vote     = {rx, smp[1], smp[0]};
	wire [1:0] n_one    = ones3(vote);
	wire       bit_val  = n_one >= 2'h2;
	wire       disagree = (vote != 3'h0) & (vote != 3'h7);

	wire start_edge  = (state == S_SEARCH) & BAUD_TICK & (hist == HIST_HI) & ~rx;
	wire chk_start   = recv & in_start & (rt == RT_S7);
	wire start_bad   = chk_start & bit_val;
	wire start_noisy = chk_start & (n_one == 2'h1);
	wire start_late  = recv & in_start & rx & (rt >= RT_S8) & (rt <= RT_S10);
	wire bit_done    = recv & ~in_start & (rt == RT_S10);
	wire data_done   = bit_done & in_data;
	wire stop_done   = bit_done & in_stop;
	wire edge_seen   = recv & in_data & hist[0] & ~rx;
	wire late_edge   = edge_seen & (rt >= RT_LATE) & (idx < nb);
	wire resync      = (edge_seen & (rt <= RT_EARLY)) | late_edge;

	// standby: only an address mark gets through
	wire wake_addr = receiver_wakeup_ctl & ctl1[C1_WAKE] & sh[8];
	wire accept    = ~receiver_wakeup_ctl | wake_addr;
	wire char_xfer = stop_done & accept;
	wire idle_hit  = (state == S_SEARCH) & BAUD_TICK & rx & idle_armed
		& (idle_sub == 4'hf) & (idle_cnt == stop_idx);
	wire idle_wake = idle_hit & receiver_wakeup_ctl & ~ctl1[C1_WAKE];

	////////////////////////////////////////////////////////////////////////
	// character sequencer
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state <= S_SEARCH;
			rt <= RT_FIRST;
			idx <= 4'h0;
		end
		else if (start_edge)
		begin
			state <= S_RECV;
			rt <= RT_NEXT;
			idx <= 4'h0;
		end
		else if (start_bad | stop_done)
		begin
			state <= S_SEARCH;
			rt <= RT_FIRST;
		end
		else if (resync)
		begin
			rt <= RT_NEXT;
			idx <= late_edge ? idx + 4'h1 : idx;
		end
		else if (recv)
		begin
			rt <= (rt == RT_LAST) ? RT_FIRST : rt + 5'h01;
			idx <= (rt == RT_LAST) ? idx + 4'h1 : idx;
		end
	end

	// sample history, votes and shift register
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			hist <= 3'h0;
			smp <= 2'h0;
			sh <= 9'h0;
			noise_acc <= 1'b0;
			run <= 4'h0;
		end
		else if (BAUD_TICK)
		begin
			hist <= {hist[1:0], rx};
			if (rt == RT_S3 || rt == RT_S8)
				smp[0] <= rx;
			if (rt == RT_S5 || rt == RT_S9)
				smp[1] <= rx;
			if (start_edge)
				noise_acc <= 1'b0;
			else if (start_noisy | start_late | (data_done & disagree))
				noise_acc <= 1'b1;
			if (data_done)
			begin
				sh <= {bit_val, sh[8:1]};
				run <= bit_val ? run + 4'h1 : 4'h0;
			end
			else if (start_edge)
				run <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// idle line detection; count is in whole bit times of high line
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			idle_sub <= 4'h0;
			idle_cnt <= 4'h0;
			idle_armed <= 1'b1;
		end
		else
		begin
			if (stop_done)
			begin
				idle_sub <= 4'h0;
				idle_cnt <= (ctl1[C1_IDLE_COUNT_TYPE] | ~bit_val) ? 4'h0 : run + 4'h1;
			end
			else if ((state == S_SEARCH) & BAUD_TICK)
			begin
				idle_sub <= rx ? idle_sub + 4'h1 : 4'h0;
				if (~rx)
					idle_cnt <= 4'h0;
				else if (idle_sub == 4'hf && idle_cnt != 4'hf)
					idle_cnt <= idle_cnt + 4'h1;
			end
			if (chk_start & ~bit_val)
				idle_armed <= 1'b1;
			else if (idle_hit)
				idle_armed <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// buffer, flags and control; a flag set beats a clear in one cycle
	assign next_buf = ctl1[C1_NINE] ? sh[7:0] : sh[8:1];
	assign next_flags = (flags & ~(wr_st ? AVS_WRITEDATA[3:0] : 4'h0))
		| {idle_hit & ~receiver_wakeup_ctl, char_xfer & ~bit_val,
		char_xfer & (noise_acc | disagree), char_xfer};

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			flags <= 4'h0;
			data_buf <= 8'h0;
			r8 <= 1'b0;
			ctl1 <= CTL1_RST;
			mask <= MASK_RST;
			receiver_wakeup_ctl <= 1'b0;
		end
		else
		begin
			flags <= next_flags;
			if (char_xfer)
			begin
				data_buf <= next_buf;
				r8 <= ctl1[C1_NINE] & sh[8];
			end
			if (wr_c1)
				ctl1 <= AVS_WRITEDATA[2:0];
			if (wr_msk)
				mask <= AVS_WRITEDATA[3:0];
			// a wake must not be lost to a write in the same cycle
			if ((stop_done & wake_addr) | idle_wake)
				receiver_wakeup_ctl <= 1'b0;
			else if (wr_c2)
				receiver_wakeup_ctl <= AVS_WRITEDATA[C2_RWU];
		end
	end

	assign IRQ = |(flags & mask) & ~receiver_wakeup_ctl;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	sync_pipe_a: assert property ($past(RST_N, 2) |-> rx == $past(RXD, 2))
		else $error("receive pin not delayed by two flops");
	hold_tick_a: assert property (!BAUD_TICK && !start_edge |=> $stable(rt))
		else $error("tick count moved without a tick");
	start_find_a: assert property (start_edge |=> state == S_RECV && rt == 5'h02 && idx == 4'h0)
		else $error("start edge not taken");
	start_reject_a: assert property (start_bad |=> state == S_SEARCH && rt == 5'h01)
		else $error("bad start not rejected");
	start_noise_a: assert property ((start_noisy || start_late) |=> noise_acc)
		else $error("start noise lost");
	late_start_a: assert property (start_late |=> state == S_RECV)
		else $error("verified start dropped");
	data_vote_a: assert property (data_done |=> sh[8] == $past(n_one >= 2'h2)
		&& (!$past(disagree) || noise_acc))
		else $error("data vote or noise wrong");
	frame_err_a: assert property (char_xfer && !bit_val |=> flags[F_FRAME] && flags[F_FULL])
		else $error("framing error not with full");
	buf_load_a: assert property (char_xfer |=> flags[F_FULL] && data_buf == $past(next_buf))
		else $error("buffer not loaded");
	resync_a: assert property (resync |=> rt == 5'h02)
		else $error("no resync on edge");
	stby_irq_a: assert property (receiver_wakeup_ctl |-> !IRQ)
		else $error("interrupt in standby");
	addr_wake_a: assert property (stop_done && wake_addr |=> !receiver_wakeup_ctl && flags[F_FULL])
		else $error("address mark did not wake");
	idle_wake_a: assert property (idle_wake |=> !receiver_wakeup_ctl && !$rose(flags[F_IDLE])
		&& !$rose(flags[F_FULL]))
		else $error("idle wake wrong");
	resume_a: assert property (stop_done |=> state == S_SEARCH)
		else $error("search not resumed");
	stop_noise_a: assert property (char_xfer && disagree |=> flags[F_NOISE])
		else $error("stop disagreement without noise");
	buf_keep_a: assert property (!char_xfer |=> data_buf == $past(data_buf))
		else $error("buffer moved without a character");
	ninth_bit_a: assert property (char_xfer && ctl1[C1_NINE] |=> r8 == $past(sh[8]))
		else $error("ninth bit not kept");
	late_resync_a: assert property (late_edge |=> idx == $past(idx) + 4'h1)
		else $error("early edge did not start next bit");

	rej_c: cover property (start_bad);
	frame_c: cover property (char_xfer && !bit_val);
	wake_c: cover property (stop_done && wake_addr);
	idle_c: cover property (idle_hit);
	nine_c: cover property (char_xfer && ctl1[C1_NINE]);
endmodule

// ===== asr_pkg.sv
/*
 asr_pkg: register map, field positions, sample points and state codes
 of the asynchronous serial receiver.
 assumes: compiled before asr_receiver; byte addresses on a 32-bit bus.
*/
package asr_pkg;
	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [4:0] OFS_DATA = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_CTL1 = 5'h08;
	localparam logic [4:0] OFS_CTL2 = 5'h0c;
	localparam logic [4:0] OFS_MASK = 5'h10;
	////////////////////////////////////////////////////////////////////////
	// status: sticky flags, then read-only bits
	localparam int FLAG_W  = 4;
	localparam int F_FULL  = 0;
	localparam int F_NOISE = 1;
	localparam int F_FRAME = 2;
	localparam int F_IDLE  = 3;
	localparam int F_R8    = 4;
	localparam int F_BUSY  = 5;
	// control one and two
	localparam int C1_NINE = 0;
	localparam int C1_WAKE = 1;
	localparam int C1_IDLE_COUNT_TYPE = 2;
	localparam int C2_RWU  = 0;
	// reset values, and the all-high start-search history
	localparam logic [2:0] CTL1_RST = 3'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [2:0] HIST_HI  = 3'h7;
	////////////////////////////////////////////////////////////////////////
	// oversample tick positions inside one bit time, then last data bit indices
	localparam logic [4:0] RT_FIRST = 5'h01;
	localparam logic [4:0] RT_NEXT  = 5'h02;
	localparam logic [4:0] RT_S3    = 5'h03;
	localparam logic [4:0] RT_S5    = 5'h05;
	localparam logic [4:0] RT_S7    = 5'h07;
	localparam logic [4:0] RT_S8    = 5'h08;
	localparam logic [4:0] RT_S9    = 5'h09;
	localparam logic [4:0] RT_S10   = 5'h0a;
	localparam logic [4:0] RT_EARLY = 5'h04;
	localparam logic [4:0] RT_LATE  = 5'h0b;
	localparam logic [4:0] RT_LAST  = 5'h10;
	localparam logic [3:0] IDX_B8   = 4'h8;
	localparam logic [3:0] IDX_B9   = 4'h9;

	typedef enum logic {S_SEARCH = 1'b0, S_RECV = 1'b1} asr_state_e;
endpackage

// ===== asr_serial_tx.sv
/*
 asr_serial_tx: remote transmitter model driving the receive line.
 assumes: BAUD_TICK pulses at 16x baud; go comes one cycle after a tick.
*/
`timescale 1ns/1ps
module asr_serial_tx
(
	input  wire logic        MCLK,
	input  wire logic        BAUD_TICK,
	input  wire logic        go,
	input  wire logic [21:0] bits,
	input  wire logic [4:0]  len,
	input  wire logic [4:0]  bt,
	input  wire logic [3:0]  fb,
	input  wire logic [4:0]  ft,
	input  wire logic [4:0]  fl,
	output logic             RXD,
	output logic             busy
);
	logic [4:0] tk;
	logic [4:0] bi;
	logic       hit;
	logic       last;

	initial busy = 1'b0;
	////////////////////////////////////////
	// bt ticks a bit; 15 or 17 only to drift against the receiver
	assign last = (tk == bt - 5'h01);
	always @(posedge MCLK)
	begin
		if (go)
		begin
			busy <= 1'b1;
			bi   <= 5'h00;
			tk   <= 5'h00;
		end
		else if (busy && BAUD_TICK)
		begin
			tk <= last ? 5'h00 : tk + 5'h01;
			if (last)
			begin
				bi   <= bi + 5'h01;
				busy <= (bi != len - 5'h01);
			end
		end
	end
	// a run of ticks in one bit may be upset to mimic noise
	assign hit = ({1'b0, fb} == bi) && (tk >= ft) && (tk < ft + fl);
	// released line idles high through its pull-up
	assign RXD = busy ? bits[bi] ^ hit : 1'b1;
endmodule

// ===== testbench.sv
/*
 testbench: random and corner characters into asr_receiver via a
 transmitter model; registers over Avalon-MM.
 assumes: asr_pkg, asr_receiver, asr_serial_tx compiled before it.
*/
`timescale 1ns/1ps
module testbench
	import asr_pkg::*;
;
	logic        MCLK = 1'b0;
	logic        RST_N = 1'b0;
	logic        BAUD_TICK = 1'b0;
	logic        RXD;
	logic [4:0]  AVS_ADDRESS = 5'h00;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        IRQ;
	logic        go = 1'b0;
	logic        busy;
	logic [21:0] bits = 22'h3fffff;
	logic [4:0]  len = 5'h0a;
	logic [4:0]  bt = 5'h10;
	logic [3:0]  fb = 4'hf;
	logic [4:0]  ft = 5'h00;
	logic [4:0]  fl = 5'h00;
	logic [1:0]  div = 2'h0;
	logic        nine = 1'b0;
	logic [31:0] smask = 32'h7;
	logic [31:0] rd;
	logic [8:0]  dv;
	integer      seed = 32'he47e26e5;
	int          n_mismatch = 0;
	int          cmp_count = 0;

	asr_receiver dut (.MCLK(MCLK), .RST_N(RST_N), .BAUD_TICK(BAUD_TICK), .RXD(RXD),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
	asr_serial_tx far_end (.MCLK(MCLK), .BAUD_TICK(BAUD_TICK), .go(go), .bits(bits),
		.len(len), .bt(bt), .fb(fb), .ft(ft), .fl(fl), .RXD(RXD), .busy(busy));
	////////////////////////////////////////
	always #2 MCLK = ~MCLK;
	// tick every fourth cycle keeps frames short
	always @(posedge MCLK)
	begin
		div <= div + 2'h1;
		BAUD_TICK <= (div == 2'h3);
	end

	task report_and_stop;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// request stands until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
		@(posedge MCLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= wd;
		@(posedge MCLK);
		while (AVS_WAITREQUEST !== 1'b0)
			@(posedge MCLK);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask

	// irq looked at one edge after the write that moves it
	task irqchk(input logic e);
		@(posedge MCLK);
		chk({31'h0, IRQ}, {31'h0, e});
	endtask

	task rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask

	function automatic logic [21:0] frm(input logic [8:0] d, input logic sb);
		frm = nine ? {10'h3ff, 1'b1, sb, d, 1'b0} : {10'h3ff, 2'h3, sb, d[7:0], 1'b0};
	endfunction

	task send(input logic [21:0] fr, input logic [4:0] n);
		bits <= fr;
		len <= n;
		@(posedge MCLK iff BAUD_TICK);
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
		@(posedge MCLK);
		while (busy)
			@(posedge MCLK);
		repeat (8)
			@(posedge MCLK);
	endtask

	task run(input logic [8:0] d, input logic sb, input logic [4:0] b, input logic [3:0] f,
		input logic [4:0] t, input logic [4:0] l, input logic [31:0] es, input logic [31:0] ed);
		bus(1'b1, OFS_STAT, 32'hf);
		bt <= b;
		fb <= f;
		ft <= t;
		fl <= l;
		send(frm(d, sb), nine ? 5'h0b : 5'h0a);
		rdchk(OFS_DATA, 32'hff, ed);
		rdchk(OFS_STAT, smask, es);
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (6)
			@(posedge MCLK);
		RST_N <= 1'b1;
		rdchk(OFS_STAT, 32'h3f, 32'h0);
		rdchk(OFS_CTL1, 32'h7, 32'h0);
		rdchk(OFS_CTL2, 32'h1, 32'h0);
		rdchk(OFS_MASK, 32'hf, 32'h0);
		rdchk(5'h14, 32'hffffffff, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			if (i == 3)
				bus(1'b1, OFS_MASK, 32'h1);
			dv = 9'($random(seed));
			run(dv, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h1, {24'h0, dv[7:0]});
			irqchk(i >= 3);
		end
		bus(1'b1, OFS_STAT, 32'hf);
		send({2'h3, 1'b1, 8'hc3, 1'b0, 1'b1, 8'h3c, 1'b0}, 5'h14);
		rdchk(OFS_DATA, 32'hff, 32'hc3);
		run(9'h0a5, 1'b1, 5'h10, 4'h0, 5'h02, 5'h01, 32'h3, 32'ha5);
		run(9'h05a, 1'b1, 5'h10, 4'h0, 5'h06, 5'h01, 32'h3, 32'h5a);
		run(9'h0c3, 1'b1, 5'h10, 4'h0, 5'h07, 5'h01, 32'h3, 32'hc3);
		run(9'h0c3, 1'b1, 5'h10, 4'h3, 5'h08, 5'h01, 32'h3, 32'hc3);
		run(9'h0c3, 1'b1, 5'h10, 4'h3, 5'h07, 5'h02, 32'h3, 32'hc7);
		run(9'h03c, 1'b1, 5'h10, 4'h9, 5'h09, 5'h01, 32'h3, 32'h3c);
		run(9'h03c, 1'b0, 5'h10, 4'hf, 5'h00, 5'h00, 32'h5, 32'h3c);
		run(9'h000, 1'b0, 5'h10, 4'hf, 5'h00, 5'h00, 32'h5, 32'h00);
		run(9'h1ff, 1'b1, 5'h10, 4'h0, 5'h02, 5'h0e, 32'h0, 32'h00);
		run(9'h055, 1'b1, 5'h11, 4'hf, 5'h00, 5'h00, 32'h1, 32'h55);
		run(9'h055, 1'b1, 5'h0f, 4'hf, 5'h00, 5'h00, 32'h1, 32'h55);
		// idle count from start bit, then from stop bit
		run(9'h0ff, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h1, 32'hff);
		repeat (192)
			@(posedge MCLK);
		rdchk(OFS_STAT, 32'h8, 32'h8);
		bus(1'b1, OFS_CTL1, 32'h4);
		run(9'h0ff, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h1, 32'hff);
		repeat (192)
			@(posedge MCLK);
		rdchk(OFS_STAT, 32'h8, 32'h0);
		repeat (640)
			@(posedge MCLK);
		rdchk(OFS_STAT, 32'h8, 32'h8);
		bus(1'b1, OFS_CTL1, 32'h1);
		nine = 1'b1;
		smask = 32'h17;
		run(9'h1a5, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h11, 32'ha5);
		run(9'h05a, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h01, 32'h5a);
		nine = 1'b0;
		smask = 32'h7;
		bus(1'b1, OFS_CTL1, 32'h2);
		run(9'h081, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h1, 32'h81);
		bus(1'b1, OFS_CTL2, 32'h1);
		irqchk(1'b0);
		run(9'h012, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h0, 32'h81);
		rdchk(OFS_CTL2, 32'h1, 32'h1);
		run(9'h092, 1'b1, 5'h10, 4'hf, 5'h00, 5'h00, 32'h1, 32'h92);
		rdchk(OFS_CTL2, 32'h1, 32'h0);
		irqchk(1'b1);
		bus(1'b1, OFS_DATA, 32'h5a);
		rdchk(OFS_DATA, 32'hff, 32'h92);
		// idle-line wake: no idle and no full flag from the waking idle
		bus(1'b1, OFS_STAT, 32'hf);
		bus(1'b1, OFS_CTL1, 32'h0);
		bus(1'b1, OFS_CTL2, 32'h1);
		repeat (900)
			@(posedge MCLK);
		rdchk(OFS_CTL2, 32'h1, 32'h0);
		rdchk(OFS_STAT, 32'hf, 32'h0);
		report_and_stop();
	end

	initial
	begin
		repeat (40000)
			@(posedge MCLK);
		n_mismatch++;
		report_and_stop();
	end
endmodule
